// ==== hw/pwhcfg_pkg.sv ====
// Constants, types and helpers of the power hardware configuration word
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package pwhcfg_pkg;

	// Bus geometry
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 16;

	// Register offsets
	localparam logic [3:0]  OFS_CONFIG    = 4'h0;
	localparam logic [3:0]  OFS_CONTROL   = 4'h4;
	localparam logic [3:0]  OFS_STATUS    = 4'h8;
	localparam logic [3:0]  OFS_DETECT    = 4'hC;

	// Field positions of the configuration word
	localparam int          MARK_LSB      = 13;
	localparam int          BRAKE_BIT     = 12;
	localparam int          ZERO_BIT      = 11;
	localparam int          DCDC_BIT      = 10;
	localparam int          SAFETY_BIT    = 9;
	localparam int          RFI_BIT       = 8;
	localparam int          VCLASS_LSB    = 6;
	localparam int          CURRENT_LSB   = 0;
	localparam logic [2:0]  MARK_VALUE    = 3'h6;

	// Voltage classes
	localparam logic [1:0]  VCLASS_240    = 2'h0;
	localparam logic [1:0]  VCLASS_480    = 2'h1;
	localparam logic [1:0]  VCLASS_600    = 2'h2;

	// Frame sizes
	localparam logic [2:0]  FRAME_A       = 3'h0;
	localparam logic [2:0]  FRAME_B       = 3'h1;
	localparam logic [2:0]  FRAME_C       = 3'h2;
	localparam logic [2:0]  FRAME_D       = 3'h3;
	localparam logic [2:0]  FRAME_E       = 3'h4;

	// Control and status fields
	localparam int          CTRL_BLANK    = 0;
	localparam int          STAT_VALID    = 0;
	localparam int          STAT_SETTLE   = 1;

	// Reset values
	localparam logic [15:0] CONFIG_RESET  = 16'hC000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;

	// Timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          SETTLE_US     = 10;
	localparam int          SETTLE_CYCLES = (SETTLE_US * 1000) / CLK_PERIOD_NS;
	localparam int          SCAN_US       = 1000;
	localparam int          SCAN_CYCLES   = (SCAN_US * 1000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {PH_SETTLE, PH_CAPTURE, PH_RUN} pwhcfg_phase_t;

	// Seven segment pattern, bit 0 is segment a, active high
	function automatic logic [6:0] pwhcfg_hex_seg(input logic [3:0] nib);
		logic [6:0] seg;
		seg = 7'h00;
		case (nib)
			4'h0: seg = 7'h3F;
			4'h1: seg = 7'h06;
			4'h2: seg = 7'h5B;
			4'h3: seg = 7'h4F;
			4'h4: seg = 7'h66;
			4'h5: seg = 7'h6D;
			4'h6: seg = 7'h7D;
			4'h7: seg = 7'h07;
			4'h8: seg = 7'h7F;
			4'h9: seg = 7'h6F;
			4'hA: seg = 7'h77;
			4'hB: seg = 7'h7C;
			4'hC: seg = 7'h39;
			4'hD: seg = 7'h5E;
			4'hE: seg = 7'h79;
			default: seg = 7'h71;
		endcase
		return seg;
	endfunction : pwhcfg_hex_seg

endpackage : pwhcfg_pkg

// ==== hw/pwhcfg_digit_scan.sv ====
// Keypad scanner showing a 16-bit word as four hexadecimal digits
`timescale 1ns/100ps
module pwhcfg_digit_scan
	import pwhcfg_pkg::*;
#(
	parameter int SCAN_CNT = SCAN_CYCLES
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Word to show
	input  wire logic [15:0] word,
	input  wire logic        blank,
	// Display drive
	output logic [6:0]       segments,
	output logic [3:0]       digitEnable
);

	typedef struct packed {
		logic [31:0] divCnt;
		logic [1:0]  digitIdx;
		logic [6:0]  segments;
		logic [3:0]  digitEnable;
	} pwhcfg_scan_t;

	pwhcfg_scan_t st;
	pwhcfg_scan_t next_st;

	//------------------------------------------------------------------
	// Digit multiplexing
	//------------------------------------------------------------------
	always_comb
	begin
		logic [3:0] nib;
		logic       tick;
		nib     = 4'h0;
		next_st = st;
		tick    = (st.divCnt == 32'(SCAN_CNT - 1));
		next_st.divCnt = tick ? 32'h0 : st.divCnt + 32'h1;
		if (tick)
			next_st.digitIdx = st.digitIdx + 2'h1;
		// Digit 3 carries bits 15..12, digit 0 bits 3..0
		nib = word[{next_st.digitIdx, 2'h0} +: 4];
		next_st.segments    = blank ? 7'h00 : pwhcfg_hex_seg(nib);
		next_st.digitEnable = blank ? 4'h0 : (4'h1 << next_st.digitIdx);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign segments    = st.segments;
	assign digitEnable = st.digitEnable;

endmodule : pwhcfg_digit_scan

// ==== hw/pwhcfg_top.sv ====
// Power hardware configuration word: capture, register port and keypad
`timescale 1ns/100ps
module pwhcfg_top
	import pwhcfg_pkg::*;
#(
	parameter int SETTLE_CNT = SETTLE_CYCLES,
	parameter int SCAN_CNT   = SCAN_CYCLES
)
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [DATA_W-1:0]      regRdData,
	// Hardware detection
	input  wire logic              brakeSwitchFitted,
	input  wire logic              dcdc24Fitted,
	input  wire logic              safetyRelayFitted,
	input  wire logic              rfiFilterFitted,
	input  wire logic [1:0]        voltageClass,
	input  wire logic [2:0]        frameSize,
	input  wire logic [5:0]        currentCode,
	// Keypad display
	output logic [6:0]             keypadSegments,
	output logic [3:0]             keypadDigitEnable,
	// Captured word
	output logic [15:0]            powerHardwareConfiguration,
	output logic                   configValid
);

	typedef struct packed {
		pwhcfg_phase_t phase;
		logic [31:0]   settleCnt;
		logic [15:0]   configWord;
		logic [15:0]   control;
		logic [15:0]   rdData;
		logic          valid;
	} pwhcfg_state_t;

	pwhcfg_state_t st;
	pwhcfg_state_t next_st;
	logic [15:0]   detectWord;
	logic [15:0]   liveView;

	//------------------------------------------------------------------
	// Word assembly from the detection inputs
	//------------------------------------------------------------------
	always_comb
	begin
		logic highClass;
		highClass  = (voltageClass == VCLASS_600);
		detectWord = 16'h0000;
		detectWord[MARK_LSB +: 3] = MARK_VALUE;
		// Low means fitted; frame D high-voltage cannot see it missing
		detectWord[BRAKE_BIT] = !brakeSwitchFitted
			&& !(highClass && frameSize == FRAME_D);
		detectWord[ZERO_BIT]   = 1'b0;
		detectWord[DCDC_BIT]   = !dcdc24Fitted;
		detectWord[SAFETY_BIT] = safetyRelayFitted;
		// Frame B high-voltage cannot see a fitted filter
		detectWord[RFI_BIT] = rfiFilterFitted
			&& !(highClass && frameSize == FRAME_B);
		detectWord[VCLASS_LSB +: 2]  = voltageClass;
		detectWord[CURRENT_LSB +: 6] = currentCode;
	end

	// Raw inputs as seen now, for diagnosis only
	assign liveView = {5'h00, frameSize, brakeSwitchFitted, dcdc24Fitted,
		safetyRelayFitted, rfiFilterFitted, voltageClass, 2'h0};

	//------------------------------------------------------------------
	// Capture sequence and register port
	//------------------------------------------------------------------
	always_comb
	begin
		next_st        = st;
		next_st.rdData = 16'h0000;
		case (st.phase)
			PH_SETTLE:
			begin
				// Let the detection straps settle before sampling them
				if (st.settleCnt == 32'(SETTLE_CNT - 1))
					next_st.phase = PH_CAPTURE;
				else
					next_st.settleCnt = st.settleCnt + 32'h1;
			end
			PH_CAPTURE:
			begin
				next_st.configWord = detectWord;
				next_st.valid      = 1'b1;
				next_st.phase      = PH_RUN;
			end
			PH_RUN:
			begin
				next_st.phase = PH_RUN;
			end
			default:
			begin
				next_st.phase = PH_SETTLE;
			end
		endcase

		// Only the control register accepts writes; the word is read-only
		if (regWrite && regAddr == OFS_CONTROL)
			next_st.control = {15'h0000, regWrData[CTRL_BLANK]};

		if (regRead)
		begin
			case (regAddr)
				OFS_CONFIG:  next_st.rdData = st.configWord;
				OFS_CONTROL: next_st.rdData = st.control;
				OFS_STATUS:  next_st.rdData = {14'h0000,
					st.phase == PH_SETTLE, st.valid};
				OFS_DETECT:  next_st.rdData = liveView;
				default:     next_st.rdData = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st            <= '0;
			st.phase      <= PH_SETTLE;
			st.configWord <= CONFIG_RESET;
			st.control    <= CONTROL_RESET;
		end
		else
			st <= next_st;
	end

	assign regRdData                  = st.rdData;
	assign powerHardwareConfiguration = st.configWord;
	assign configValid                = st.valid;

	//------------------------------------------------------------------
	// Keypad
	//------------------------------------------------------------------
	pwhcfg_digit_scan #(
		.SCAN_CNT    (SCAN_CNT)
	) u_scan (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.word        (st.configWord),
		.blank       (st.control[CTRL_BLANK] || !st.valid),
		.segments    (keypadSegments),
		.digitEnable (keypadDigitEnable)
	);

endmodule : pwhcfg_top

// ==== verification/pwhcfg_props.sv ====
// Checker for the power hardware configuration word ports
`timescale 1ns/100ps
module pwhcfg_props
	import pwhcfg_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regRead,
	input wire logic [DATA_W-1:0] regRdData,
	// Detection inputs and outputs
	input wire logic              brakeSwitchFitted,
	input wire logic              rfiFilterFitted,
	input wire logic [1:0]        voltageClass,
	input wire logic [2:0]        frameSize,
	input wire logic [5:0]        currentCode,
	input wire logic [3:0]        keypadDigitEnable,
	input wire logic [15:0]       powerHardwareConfiguration,
	input wire logic              configValid
);
	//------------------------------------------------------------
	// Properties
	//------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire hv = (voltageClass == VCLASS_600);

	a_mark_bits: assert property (configValid |-> powerHardwareConfiguration[15:13] == 3'h6)
		else $error("marker bits wrong");
	a_brake_bit: assert property ($rose(configValid) |-> powerHardwareConfiguration[12]
		== (!brakeSwitchFitted && !(hv && frameSize == FRAME_D))) else $error("brake bit wrong");
	a_zero_bit: assert property (configValid |-> !powerHardwareConfiguration[11])
		else $error("bit 11 not zero");
	a_rfi_bit: assert property ($rose(configValid) |-> powerHardwareConfiguration[8]
		== (rfiFilterFitted && !(hv && frameSize == FRAME_B))) else $error("filter bit wrong");
	a_class_code: assert property ($rose(configValid) |->
		powerHardwareConfiguration[7:0] == {voltageClass, currentCode}) else $error("low byte wrong");
	a_word_frozen: assert property (configValid |=> $stable(powerHardwareConfiguration))
		else $error("word changed while running");
	a_read_word: assert property (regRead && regAddr == OFS_CONFIG && configValid |=>
		regRdData == powerHardwareConfiguration) else $error("read data wrong");
	a_digit_onehot: assert property ($onehot0(keypadDigitEnable))
		else $error("digit enable not one-hot");
	c_capture: cover property ($rose(configValid));
	c_read: cover property (regRead && regAddr == OFS_CONFIG);
	c_top_digit: cover property (keypadDigitEnable == 4'h8);
endmodule : pwhcfg_props

bind pwhcfg_top pwhcfg_props i_props (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
	.regRead(regRead), .regRdData(regRdData), .brakeSwitchFitted(brakeSwitchFitted),
	.rfiFilterFitted(rfiFilterFitted), .voltageClass(voltageClass), .frameSize(frameSize),
	.currentCode(currentCode), .keypadDigitEnable(keypadDigitEnable),
	.powerHardwareConfiguration(powerHardwareConfiguration), .configValid(configValid));

// ==== verification/pwhcfg_tb.sv ====
// Testbench for the power hardware configuration word
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module pwhcfg_tb
	import pwhcfg_pkg::*;
;
	logic              sys_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, vld;
	logic [ADDR_W-1:0] regAddr = 0;
	logic [DATA_W-1:0] regWrData = 0, rdData, pw, cfgWord;
	logic [3:0]        fit = 0, digEn;
	logic [1:0]        vClass = 0;
	logic [2:0]        frame = 0;
	logic [5:0]        cur = 0;
	logic [6:0]        seg;
	int                n_fail = 0, num_checks = 0;
	// Fitted flags brake,dcdc,safety,rfi then class, frame, current code
	logic [14:0] cases [6] = '{{4'h9, 2'h1, 3'h0, 6'h04}, {4'h7, 2'h2, 3'h3, 6'h06},
		{4'h1, 2'h2, 3'h1, 6'h0A}, {4'h6, 2'h0, 3'h2, 6'h0D}, {4'h1, 2'h1, 3'h1, 6'h3F},
		{4'h0, 2'h2, 3'h4, 6'h15}};
	logic [6:0] hexSeg [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

	pwhcfg_top #(.SETTLE_CNT(4), .SCAN_CNT(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(rdData), .brakeSwitchFitted(fit[3]), .dcdc24Fitted(fit[2]),
		.safetyRelayFitted(fit[1]), .rfiFilterFitted(fit[0]), .voltageClass(vClass),
		.frameSize(frame), .currentCode(cur), .keypadSegments(seg), .keypadDigitEnable(digEn),
		.powerHardwareConfiguration(pw), .configValid(vld));

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	//------------------------------------------------------------
	// Expected word and bus tasks
	//------------------------------------------------------------
	function automatic logic [15:0] expw(input logic [14:0] c);
		logic hv;
		hv = (c[10:9] == VCLASS_600);
		return {3'h6, !c[14] && !(hv && c[8:6] == FRAME_D), 1'b0, !c[13], c[12],
			c[11] && !(hv && c[8:6] == FRAME_B), c[10:9], c[5:0]};
	endfunction : expw

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regWrite  <= 1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrite  <= 0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		regRead <= 1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 0;
		// Read data stand in this cycle only; look at them once settled
		@(negedge sys_clk);
		`CHK(rdData, e)
	endtask : rd

	task automatic waitFor(input logic [3:0] e, input logic v);
		for (int k = 0; k < 40 && (v ? vld !== 1'b1 : digEn !== e); k++)
			@(negedge sys_clk);
		if (v ? vld !== 1'b1 : digEn !== e)
		begin
			$display("ERROR %0t wait ran out", $time);
			n_fail++;
			conclude();
		end
	endtask : waitFor

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial
	begin
		foreach (cases[i])
		begin
			// Later passes start on a rising edge so the inputs move with the clock
			if (i > 0)
				@(posedge sys_clk);
			{fit, vClass, frame, cur} <= cases[i];
			rst_n <= 0;
			repeat (2) @(posedge sys_clk);
			rst_n   <= 1;
			cfgWord = expw(cases[i]);
			rd(OFS_STATUS, 16'h0002);
			`CHK(vld, 1'b0)
			`CHK(pw, CONFIG_RESET)
			`CHK(digEn, 4'h0)
			waitFor(4'h0, 1);
			rd(OFS_CONFIG, cfgWord);
			wr(OFS_CONFIG, 16'hFFFF);
			fit <= ~fit;
			cur <= ~cur;
			rd(OFS_CONFIG, cfgWord);
			`CHK(pw, cfgWord)
		end
		for (int n = 0; n < 4; n++)
		begin
			waitFor(4'h1 << n, 0);
			`CHK(seg, hexSeg[cfgWord[4*n +: 4]])
		end
		rd(OFS_STATUS, 16'h0001);
		rd(OFS_DETECT, {5'h00, frame, fit, vClass, 2'h0});
		rd(4'h2, 16'h0000);
		wr(OFS_CONTROL, 16'h0001);
		rd(OFS_CONTROL, 16'h0001);
		repeat (3) @(negedge sys_clk);
		`CHK(digEn, 4'h0)
		`CHK(seg, 7'h00)
		conclude();
	end
endmodule : pwhcfg_tb
